//--- hw/ipc_defs.svh
/*
  Register offsets, field positions, widths and reset values of the
  interrupt post/clear and mask bank.
  Assumes an 8-bit register port addressed by byte offset.
*/
`ifndef IPC_DEFS_SVH
`define IPC_DEFS_SVH

// register port widths
`define IPC_ADDR_W 8
`define IPC_DATA_W 8

// register offsets
`define IPC_ADDR_POST0 8'hDA
`define IPC_ADDR_POST1 8'hDB
`define IPC_ADDR_POST2 8'hDC
`define IPC_ADDR_MASK2 8'hDE
`define IPC_ADDR_MASK1 8'hDF
`define IPC_ADDR_MASK0 8'hE0
`define IPC_ADDR_SWEN 8'hE1

// source counts per group and in total
`define IPC_G0_W 8
`define IPC_G1_W 8
`define IPC_G2_W 6
`define IPC_NUM_SRC 22
`define IPC_VEC_W 5

// flat source positions of each group
`define IPC_G0_LSB 0
`define IPC_G1_LSB 8
`define IPC_G2_LSB 16

// software-enable field position
`define IPC_SWEN_BIT 0

// reset values
`define IPC_RST_BYTE 8'h00
`define IPC_RST_G2 6'h00
`define IPC_RST_SRC 22'h000000
`define IPC_RST_VEC 5'h00

`endif

//--- hw/ipc_pkg.sv
/*
  Types shared by the interrupt post/clear and mask bank.
  Assumes ipc_defs.svh is on the include path.
*/
`include "ipc_defs.svh"

package ipc_pkg;
  // one register byte
  typedef logic [`IPC_DATA_W-1:0] ipc_byte_t;
  // one bit per interrupt source, bit 0 is the highest priority
  typedef logic [`IPC_NUM_SRC-1:0] ipc_src_t;
  // index of a source as presented to the core
  typedef logic [`IPC_VEC_W-1:0] ipc_vec_t;
endpackage

//--- hw/ipc_post_cell.sv
/*
  One posted-interrupt flag with hardware set, software post, software
  clear and service clear.
  Assumes all inputs come from logic on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ipc_post_cell (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic hw_set,
  input wire logic sw_post,
  input wire logic sw_clear,
  input wire logic svc_clear,
  output logic posted_r,
  output logic posted_nxt
);
  // any set beats any clear in the same cycle
  assign posted_nxt = hw_set | sw_post | (posted_r & ~(sw_clear | svc_clear));

  // flag flop, frozen while clk_en is low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      posted_r <= 1'b0;
    end else if (clk_en) begin
      posted_r <= posted_nxt;
    end
  end
endmodule

`default_nettype wire

//--- hw/ipc_prio_enc.sv
/*
  Fixed-priority encoder: lowest set index wins.
  Assumes sources are ordered by priority, index 0 the highest.
*/
`timescale 1ns/1ps
`default_nettype none

module ipc_prio_enc #(
  parameter int N = 22,
  parameter int W = 5
) (
  input wire logic [N-1:0] pending,
  output logic any,
  output logic [W-1:0] idx
);
  assign any = |pending;

  // scan from the bottom of the table upward so the top entry wins last
  always_comb begin
    idx = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (pending[k]) begin
        idx = W'(k);
      end
    end
  end
endmodule

`default_nettype wire

//--- hw/ipc_bank.sv
/*
  Interrupt post/clear and mask bank with fixed-priority presentation
  to the cpu_core.
  Holds three post/clear registers, three mask registers and the
  soft-enable flag, one posted flag per source, and a registered
  request and vector for the core.
  Assumes a single ref_clk domain, peripheral requests from logic on
  that clock, and a register master that never strobes read and write
  together. The core answers with a one-cycle service pulse that
  clears the source named by the vector.
*/
// Design decision made here: strobed register access.
// Summary of operation
// RL1: reading post register shows posted sources
// RL2: write zero, soft enable off: clears post
// RL3: write one, soft enable on: posts interrupt
// RL4: other write combinations leave post unchanged
// RL5: group two: bit5 wakeup, bits4-0 endpoints
// RL6: cleared mask keeps post from pending
// RL7: masked sources still post
// RL8: each mask bit affects only itself
// RL9: set mask makes posted source pending
// RL10: higher priority pending is presented first
// RL11: mask zero bits 7-0 fixed order
// RL12: mask one: endpoints, frame, reset, timers
// RL13: mask two: wakeup and endpoints 8-4
// RL14: software writes zero to reserved bits
// RL15: soft enable is bit0, resets zero
// RL16: fixed priority table, index zero highest
// RL17: masks and posts reset to zero
// RL18: hardware set beats clearing write
`timescale 1ns/1ps
`default_nettype none
`include "ipc_defs.svh"

module ipc_bank (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [`IPC_ADDR_W-1:0] addr,
  input wire logic [`IPC_DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [`IPC_DATA_W-1:0] rdata,
  input wire logic [`IPC_NUM_SRC-1:0] src_req,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [`IPC_VEC_W-1:0] irq_vec
);

  // address decode
  // offsets outside the map select nothing, so writes there fall away
  wire logic sel_post0 = (addr == `IPC_ADDR_POST0); // group zero post/clear
  wire logic sel_post1 = (addr == `IPC_ADDR_POST1); // group one post/clear
  wire logic sel_post2 = (addr == `IPC_ADDR_POST2); // group two post/clear
  wire logic sel_mask0 = (addr == `IPC_ADDR_MASK0); // group zero mask
  wire logic sel_mask1 = (addr == `IPC_ADDR_MASK1); // group one mask
  wire logic sel_mask2 = (addr == `IPC_ADDR_MASK2); // group two mask
  wire logic sel_swen = (addr == `IPC_ADDR_SWEN); // software-enable

  // qualified write strobes; clk_en gates them so a frozen block drops nothing late
  // reads need no gate here: the read data flop is frozen by clk_en itself
  wire logic wr_post0 = wr_en & clk_en & sel_post0;
  wire logic wr_post1 = wr_en & clk_en & sel_post1;
  wire logic wr_post2 = wr_en & clk_en & sel_post2;
  wire logic wr_mask0 = wr_en & clk_en & sel_mask0;
  wire logic wr_mask1 = wr_en & clk_en & sel_mask1;
  wire logic wr_mask2 = wr_en & clk_en & sel_mask2;
  wire logic wr_swen = wr_en & clk_en & sel_swen;

  // control and state registers
  ipc_pkg::ipc_byte_t mask0_r; // mask group zero, 1 = unmasked
  ipc_pkg::ipc_byte_t mask1_r; // mask group one
  // group two keeps only six live bits; reads pad the top two with zeros
  logic [`IPC_G2_W-1:0] mask2_r; // mask group two, bits 7:6 absent
  logic swen_r; // software-interrupt enable
  wire ipc_pkg::ipc_src_t posted_r; // posted flags, flat, one cell per bit
  wire ipc_pkg::ipc_src_t posted_nxt; // next posted flags
  ipc_pkg::ipc_vec_t irq_vec_r; // presented source index
  logic irq_req_r; // any source pending
  ipc_pkg::ipc_byte_t rdata_r; // read data, one cycle after strobe

  // next-values of the masks, so the vector tracks a write in the same edge
  ipc_pkg::ipc_byte_t mask0_nxt;
  ipc_pkg::ipc_byte_t mask1_nxt;
  logic [`IPC_G2_W-1:0] mask2_nxt;
  assign mask0_nxt = wr_mask0 ? wdata : mask0_r; // [RL11]
  assign mask1_nxt = wr_mask1 ? wdata : mask1_r; // [RL12]
  assign mask2_nxt = wr_mask2 ? wdata[`IPC_G2_W-1:0] : mask2_r; // [RL13]

  // flat mask vectors in priority order
  ipc_pkg::ipc_src_t mask_w;
  ipc_pkg::ipc_src_t mask_nxt_w;
  assign mask_w = {mask2_r, mask1_r, mask0_r};
  assign mask_nxt_w = {mask2_nxt, mask1_nxt, mask0_nxt};

  // pending = posted and unmasked, bit by bit
  ipc_pkg::ipc_src_t pending_w;
  ipc_pkg::ipc_src_t pending_nxt;
  assign pending_w = posted_r & mask_w; // [RL6] [RL8]
  assign pending_nxt = posted_nxt & mask_nxt_w; // [RL9]

  // one-hot service clear for the source the core just took
  // the vector flop always names the live top source, so no compare is needed
  ipc_pkg::ipc_src_t svc_onehot;
  assign svc_onehot = (irq_ack && irq_req_r) ?
                      (ipc_pkg::ipc_src_t'(1) << irq_vec_r) : '0;

  // write data spread over the flat source map
  ipc_pkg::ipc_src_t wr_grp_w; // source sits in the written post register
  ipc_pkg::ipc_src_t wr_bit_w; // written bit value for that source
  assign wr_grp_w = {{`IPC_G2_W{wr_post2}}, {`IPC_G1_W{wr_post1}}, {`IPC_G0_W{wr_post0}}};
  assign wr_bit_w = {wdata[`IPC_G2_W-1:0], wdata, wdata}; // [RL5] bits 7:6 of group two dropped

  // one flag per source; masks never feed the set path
  // a set from hardware or software wins over any clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `IPC_NUM_SRC; gi++) begin : g_src
      wire logic sw_post_w;
      wire logic sw_clear_w;
      // write one with soft enable posts; write zero without it clears
      assign sw_post_w = wr_grp_w[gi] & swen_r & wr_bit_w[gi]; // [RL3]
      assign sw_clear_w = wr_grp_w[gi] & ~swen_r & ~wr_bit_w[gi]; // [RL2] [RL4]
      ipc_post_cell u_cell (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .hw_set(src_req[gi]), // [RL7] [RL18]
        .sw_post(sw_post_w),
        .sw_clear(sw_clear_w),
        .svc_clear(svc_onehot[gi]),
        .posted_r(posted_r[gi]),
        .posted_nxt(posted_nxt[gi])
      );
    end
  endgenerate

  // priority pick on next pending, so vector and flags agree every cycle
  // this costs a longer path from the strobes, but no cycle of stale vector
  wire logic enc_any;
  ipc_pkg::ipc_vec_t enc_idx;
  ipc_prio_enc #(
    .N(`IPC_NUM_SRC),
    .W(`IPC_VEC_W)
  ) u_enc (
    .pending(pending_nxt),
    .any(enc_any),
    .idx(enc_idx)
  );

  // read mux; unmapped offsets and reserved bits read zero
  // a read has no side effect: flags fall only by a write or by service
  ipc_pkg::ipc_byte_t rd_mux;
  assign rd_mux =
    sel_post0 ? posted_r[`IPC_G1_LSB-1:`IPC_G0_LSB] :
    sel_post1 ? posted_r[`IPC_G2_LSB-1:`IPC_G1_LSB] :
    sel_post2 ? {2'h0, posted_r[`IPC_NUM_SRC-1:`IPC_G2_LSB]} : // [RL1] [RL5]
    sel_mask0 ? mask0_r :
    sel_mask1 ? mask1_r :
    sel_mask2 ? {2'h0, mask2_r} :
    sel_swen ? {7'h00, swen_r} :
    `IPC_RST_BYTE;

  // mask registers, each written only by its own strobe
  // a new mask reaches the request flop at the edge that takes the write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask0_r <= `IPC_RST_BYTE; // [RL17]
      mask1_r <= `IPC_RST_BYTE;
      mask2_r <= `IPC_RST_G2;
    end else if (clk_en) begin
      mask0_r <= mask0_nxt;
      mask1_r <= mask1_nxt;
      mask2_r <= mask2_nxt;
    end
  end

  // software-enable flag; upper bits of its register are not stored
  // it only steers writes to the post registers, never the flags themselves
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      swen_r <= 1'b0; // [RL15]
    end else if (wr_swen) begin
      swen_r <= wdata[`IPC_SWEN_BIT]; // [RL15]
    end
  end

  // presentation to the core, highest priority first
  // the core sees a one-cycle delay from any request or mask change
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req_r <= 1'b0;
      irq_vec_r <= `IPC_RST_VEC;
    end else if (clk_en) begin
      irq_req_r <= enc_any; // [RL9]
      irq_vec_r <= enc_idx; // [RL10] [RL16]
    end
  end

  // read data register; a read has no side effect on the flags
  // zero outside the answer cycle keeps the port quiet on a shared bus
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= `IPC_RST_BYTE;
    end else if (clk_en) begin
      // hold zero between reads so stale data never looks valid
      rdata_r <= rd_en ? rd_mux : `IPC_RST_BYTE;
    end
  end

  // every output comes straight from a flop
  assign rdata = rdata_r;
  assign irq_req = irq_req_r;
  assign irq_vec = irq_vec_r;

  // checks of the post, mask and presentation rules
  // group two views for the checks below
  wire logic [`IPC_G2_W-1:0] post2_w = posted_r[`IPC_NUM_SRC-1:`IPC_G2_LSB];
  wire logic [`IPC_G2_W-1:0] req2_w = src_req[`IPC_NUM_SRC-1:`IPC_G2_LSB];
  // bits of a group two write that the soft enable says to ignore
  wire logic [`IPC_G2_W-1:0] ign2_w = wdata[`IPC_G2_W-1:0] ^ {`IPC_G2_W{swen_r}};

  // read of group two returns the posted flags of the previous cycle
  read_post_a: assert property ( // [RL1]
    @(posedge ref_clk) disable iff (!rst_n)
    (clk_en && rd_en && sel_post2) |=>
      (rdata == {2'h0, $past(posted_r[`IPC_NUM_SRC-1:`IPC_G2_LSB])}))
    else $error("group two read does not match posted flags");

  // zeros written without soft enable clear their flags unless a request lands
  soft_clear_a: assert property ( // [RL2]
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_post2 && !swen_r) |=>
      ((post2_w & ~$past(wdata[`IPC_G2_W-1:0]) & ~$past(req2_w)) == '0))
    else $error("write zero did not clear a group two flag");

  // ones written with soft enable post their flags
  soft_post_a: assert property ( // [RL3]
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_post2 && swen_r) |=>
      ((post2_w & $past(wdata[`IPC_G2_W-1:0])) == $past(wdata[`IPC_G2_W-1:0])))
    else $error("write one did not post a group two flag");

  // ignored bits (one without soft enable, zero with it) keep their flags
  write_ignored_a: assert property ( // [RL4]
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_post2 && req2_w == '0 && svc_onehot == '0) |=>
      (((post2_w ^ $past(post2_w)) & $past(ign2_w)) == '0))
    else $error("ignored write changed a flag");

  // requests post whatever the mask, and a set wins over any clear
  masked_post_a: assert property ( // [RL7] [RL18]
    @(posedge ref_clk) disable iff (!rst_n)
    (clk_en && src_req != '0) |=> ((posted_r & $past(src_req)) == $past(src_req)))
    else $error("request lost while masked or cleared");

  // a group zero mask write touches no other mask register
  mask_alone_a: assert property ( // [RL8]
    @(posedge ref_clk) disable iff (!rst_n)
    wr_mask0 |=> (mask1_r == $past(mask1_r) && mask2_r == $past(mask2_r)))
    else $error("mask write disturbed another group");

  // the request tracks unmasked posted flags, and only those
  pending_gate_a: assert property ( // [RL6] [RL9]
    @(posedge ref_clk) disable iff (!rst_n)
    irq_req == (pending_w != '0))
    else $error("request does not follow posted and mask");

  // the vector names a pending source with nothing higher pending
  prio_order_a: assert property ( // [RL10]
    @(posedge ref_clk) disable iff (!rst_n)
    irq_req |->
      (pending_w[irq_vec] &&
       ((pending_w & ((ipc_pkg::ipc_src_t'(1) << irq_vec) - ipc_pkg::ipc_src_t'(1))) == '0)))
    else $error("vector is not the highest pending source");

  // soft enable follows bit zero of its register
  soft_enable_a: assert property ( // [RL15]
    @(posedge ref_clk) disable iff (!rst_n)
    wr_swen |=> (swen_r == $past(wdata[`IPC_SWEN_BIT])))
    else $error("soft enable did not take bit zero");

  // a serviced source leaves the posted set one edge later
  service_clear_a: assert property ( // [RL10]
    @(posedge ref_clk) disable iff (!rst_n)
    (clk_en && irq_ack && irq_req && !src_req[irq_vec] &&
     !(swen_r && wr_grp_w[irq_vec] && wr_bit_w[irq_vec])) |=>
      !posted_r[$past(irq_vec)])
    else $error("serviced source still posted");

  // group zero mask register takes its whole written byte
  mask_take_a: assert property ( // [RL11]
    @(posedge ref_clk) disable iff (!rst_n)
    wr_mask0 |=> (mask0_r == $past(wdata)))
    else $error("group zero mask did not take the write");

  // group one mask follows its write
  mask_mid_a: assert property ( // [RL12]
    @(posedge ref_clk) disable iff (!rst_n)
    wr_mask1 |=> (mask1_r == $past(wdata)))
    else $error("group one mask did not take the write");

  // group two mask keeps the six live bits of its write
  mask_top_a: assert property ( // [RL13]
    @(posedge ref_clk) disable iff (!rst_n)
    wr_mask2 |=> (mask2_r == $past(wdata[`IPC_G2_W-1:0])))
    else $error("group two mask did not take the write");

  // group two mask reads back what it holds
  read_mask_a: assert property ( // [RL13]
    @(posedge ref_clk) disable iff (!rst_n)
    (clk_en && rd_en && sel_mask2) |=> (rdata == {2'h0, $past(mask2_r)}))
    else $error("group two mask read back wrong");

  // unused top bits of the group two registers read zero
  reserved_zero_a: assert property ( // [RL5]
    @(posedge ref_clk) disable iff (!rst_n)
    (clk_en && rd_en && (sel_post2 || sel_mask2)) |=> (rdata[7:6] == 2'h0))
    else $error("unused group two bits read nonzero");

  // soft enable reads back in bit zero only
  read_swen_a: assert property ( // [RL15]
    @(posedge ref_clk) disable iff (!rst_n)
    (clk_en && rd_en && sel_swen) |=> (rdata == {7'h00, $past(swen_r)}))
    else $error("soft enable read back wrong");

  // the presented source is never a masked one
  vec_unmasked_a: assert property ( // [RL6]
    @(posedge ref_clk) disable iff (!rst_n)
    irq_req |-> mask_w[irq_vec])
    else $error("masked source presented to the core");

  // an unmasked request raises the core request at the next edge
  req_pending_a: assert property ( // [RL9]
    @(posedge ref_clk) disable iff (!rst_n)
    (clk_en && (src_req & mask_nxt_w) != '0) |=> irq_req)
    else $error("unmasked request did not reach the core");

  // with no post write and no service, no posted flag falls
  post_hold_a: assert property ( // [RL18]
    @(posedge ref_clk) disable iff (!rst_n)
    (clk_en && !wr_post0 && !wr_post1 && !wr_post2 && svc_onehot == '0) |=>
      ((posted_r & $past(posted_r)) == $past(posted_r)))
    else $error("posted flag fell without a clear");

endmodule

`default_nettype wire

//--- test/ipc_core_model.sv
/*
  Behavioural model of the cpu_core side: answers a presented interrupt
  with a one-cycle service pulse while servicing is switched on.
  Assumes irq_req and irq_vec are registered on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ipc_core_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ack_on,
  input wire logic irq_req,
  output logic irq_ack
);
  // service pulse, never two in a row so the vector can settle between
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= ack_on && irq_req && !irq_ack;
    end
  end
endmodule

`default_nettype wire

//--- test/tb_interrupt_post_clear_mask_bank.sv
/*
  Self-checking bench of the post/clear and mask bank.
  Assumes ipc_pkg is compiled first and the core model sits beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %0t %s", $time, m); end end

module tb_interrupt_post_clear_mask_bank;
  logic ref_clk, rst_n, clk_en, wr_en, rd_en, irq_req, irq_ack;
  logic ack_on; // lets the core model service
  ipc_pkg::ipc_byte_t addr, wdata, rdata;
  ipc_pkg::ipc_src_t src_req;
  ipc_pkg::ipc_vec_t irq_vec;
  ipc_pkg::ipc_vec_t log_q[$]; // vectors in service order
  int error_cnt = 0;
  int checked = 0;

  ipc_bank dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .src_req(src_req),
    .irq_ack(irq_ack), .irq_req(irq_req), .irq_vec(irq_vec));
  ipc_core_model core (.ref_clk(ref_clk), .rst_n(rst_n), .ack_on(ack_on),
    .irq_req(irq_req), .irq_ack(irq_ack));

  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // log each serviced vector, old values seen at the edge
  always @(posedge ref_clk) begin
    if (irq_ack && irq_req) begin
      log_q.push_back(irq_vec);
    end
  end

  task automatic give_verdict();
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(input ipc_pkg::ipc_byte_t a, input ipc_pkg::ipc_byte_t d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  // read, data judged in the single cycle after the strobe
  task automatic rd(input ipc_pkg::ipc_byte_t a, input ipc_pkg::ipc_byte_t e,
    input string m);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    `CHK(rdata, e, m)
  endtask

  // one-cycle hardware request
  task automatic pulse(input ipc_pkg::ipc_src_t v);
    @(posedge ref_clk);
    src_req <= v;
    @(posedge ref_clk);
    src_req <= '0;
  endtask

  // all registers zero, unmapped reads zero, frozen clock ignores writes
  task automatic t_reset();
    ipc_pkg::ipc_byte_t regs[8] = '{8'hDA, 8'hDB, 8'hDC, 8'hDE, 8'hDF, 8'hE0, 8'hE1, 8'hD0};
    foreach (regs[i]) rd(regs[i], 8'h00, "reset value");
    `CHK(irq_req, 1'b0, "reset request")
    `CHK(irq_vec, 5'h00, "reset vector")
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(8'hE0, 8'hFF);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(8'hE0, 8'h00, "write while frozen");
  endtask

  // masks hold what is written, reserved bits read zero
  task automatic t_masks();
    wr(8'hE0, 8'hA5);
    wr(8'hDF, 8'h5A);
    wr(8'hDE, 8'h2A); // reserved bits written zero
    rd(8'hE0, 8'hA5, "mask0");
    rd(8'hDF, 8'h5A, "mask1");
    rd(8'hDE, 8'h2A, "mask2");
    wr(8'hE0, 8'h00);
    wr(8'hDF, 8'h00);
    wr(8'hDE, 8'h00);
  endtask

  // masked sources post; zeros clear, ones do nothing
  task automatic t_clear();
    pulse(22'h230000);
    rd(8'hDC, 8'h23, "masked post");
    `CHK(irq_req, 1'b0, "masked source raised request")
    wr(8'hDC, 8'h3E);
    rd(8'hDC, 8'h22, "zero bit clears, ones ignored");
    wr(8'hDC, 8'h00);
    rd(8'hDC, 8'h00, "clear all");
  endtask

  // software posting with the soft enable set
  task automatic t_soft();
    wr(8'hE1, 8'h01);
    rd(8'hE1, 8'h01, "soft enable");
    wr(8'hDC, 8'h12);
    rd(8'hDC, 8'h12, "soft post");
    wr(8'hDC, 8'h00);
    rd(8'hDC, 8'h12, "zeros ignored when enabled");
    wr(8'hE1, 8'h00);
    wr(8'hDC, 8'h00);
    rd(8'hDC, 8'h00, "cleared after disable");
  endtask

  // one mask bit at a time picks exactly its own source
  task automatic t_route();
    ipc_pkg::ipc_src_t m;
    pulse(22'h3FFFFF);
    for (int k = 0; k < 22; k++) begin
      m = ipc_pkg::ipc_src_t'(1) << k;
      wr(8'hE0, m[7:0]);
      wr(8'hDF, m[15:8]);
      wr(8'hDE, {2'b00, m[21:16]});
      @(posedge ref_clk);
      #1;
      `CHK(irq_req, 1'b1, "unmasked request")
      `CHK(irq_vec, ipc_pkg::ipc_vec_t'(k), "routed vector")
    end
    wr(8'hDE, 8'h00);
    @(posedge ref_clk);
    #1;
    `CHK(irq_req, 1'b0, "all masked")
    rd(8'hDA, 8'hFF, "group zero posted while masked");
    rd(8'hDB, 8'hFF, "group one posted while masked");
    rd(8'hDC, 8'h3F, "group two posted while masked");
    wr(8'hDA, 8'h00);
    wr(8'hDB, 8'h00);
    rd(8'hDA, 8'h00, "group zero cleared");
    rd(8'hDB, 8'h00, "group one cleared");
    wr(8'hDC, 8'h00);
  endtask

  // later higher source overtakes, service follows priority
  task automatic t_prio();
    wr(8'hE0, 8'hFF);
    wr(8'hDF, 8'hFF);
    wr(8'hDE, 8'h3F);
    log_q.delete();
    pulse(22'h000050);
    @(posedge ref_clk);
    #1;
    `CHK(irq_vec, 5'h04, "gpio first")
    pulse(22'h000002);
    @(posedge ref_clk);
    #1;
    `CHK(irq_vec, 5'h01, "higher overtakes")
    ack_on <= 1'b1;
    for (int i = 0; i < 20 && irq_req !== 1'b0; i++) @(posedge ref_clk);
    ack_on <= 1'b0;
    `CHK(log_q.size(), 3, "service count")
    if (log_q.size() == 3) begin
      `CHK({log_q[0], log_q[1], log_q[2]}, {5'h01, 5'h04, 5'h06}, "service order")
    end
  endtask

  // request beats a clearing write in the same cycle
  task automatic t_race();
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= 8'hDC;
    wdata <= 8'h00;
    src_req <= 22'h010000;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    src_req <= '0;
    rd(8'hDC, 8'h01, "request lost to clear");
  endtask

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ack_on = 1'b0;
    addr = '0;
    wdata = '0;
    src_req = '0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_masks();
    t_clear();
    t_soft();
    t_route();
    t_prio();
    t_race();
    give_verdict();
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    give_verdict();
  end
endmodule

`default_nettype wire
